// >>> core/srcp_core.v
// record command interpreter with status handshake and word drain
`timescale 1ns/100ps
`default_nettype none
`include "srcp_map.vh"
// Summary of operation
// - rate command 5130-5134 echoed in status, reserved codes answer zero
// - rate codes map to 16,12,10,9,8 words
// - rate resets to 8.5, held until changed
// - sixteen word buffer holds one waiting frame
// - command only when accepted, read clears valid
// - poll sync command 5102 is echoed
// - first record word syncs, then echoes
// - second record word returns peak digit
// - third word grants count, opens window
// - each transfer command returns one word
// - window closes after last granted word
// - vad off at reset, 513E enables, echoed
// - frame length fixed, short frames zero padded
// - 6.3/5.3 switching keeps twelve word frames
// - unsupported switch answers zero, rate kept
// - playback frame bits examined only 6.3/5.3
// - frame type bits 00,01,10,11 decoded
// - idle or stop ends record, clears ready
module srcp_core (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata_r,
   // encoder frame source
   input wire enc_valid,
   input wire [15:0] enc_word,
   input wire enc_end,
   input wire enc_peak,
   // playback first word of each frame
   input wire play_first_valid,
   input wire [1:0] play_first_bits,
   // outputs
   output reg transfer_window_n_r,
   output reg [1:0] transfer_path_sel_r,
   output reg [1:0] play_type_r,
   output reg play_typed_r,
   output reg vad_en_r,
   output reg recording_r
);
   // ****************************************
   // states and local declarations
   // ****************************************
   // record phases: idle, sync, peak poll, count request
   localparam ST_IDLE = 2'b00;
   localparam ST_SYNC = 2'b01;
   localparam ST_C2 = 2'b10;
   localparam ST_C3 = 2'b11;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg data_phase_r;
   reg [3:0] rate_r;
   reg [4:0] sess_words_r;
   reg [4:0] left_r;
   reg [3:0] rd_idx_r;
   reg [1:0] sync_cnt_r;
   reg resp_valid_r;
   reg [15:0] status_r;
   reg poll_sync_r;
   reg peak_r;
   wire frame_full;
   wire [15:0] frame_word;
   wire cmd_ok;
   wire [15:0] flags;
   wire sync_done;
   reg release_frame;

   // frame size for a rate code, zero for reserved codes
   function [4:0] srcp_words;
      input [3:0] code;
      begin
         case (code)
            `SRCP_RATE_85: srcp_words = `SRCP_FS_85;
            `SRCP_RATE_63: srcp_words = `SRCP_FS_63;
            `SRCP_RATE_53: srcp_words = `SRCP_FS_53;
            `SRCP_RATE_48: srcp_words = `SRCP_FS_48;
            `SRCP_RATE_41: srcp_words = `SRCP_FS_41;
            default: srcp_words = 5'h00;
         endcase
      end
   endfunction

   // true for the two rates that may switch on the fly
   function srcp_g723;
      input [3:0] code;
      begin
         srcp_g723 = (code == `SRCP_RATE_63) || (code == `SRCP_RATE_53);
      end
   endfunction

   // ****************************************
   // frame store
   // ****************************************
   // one waiting frame, short frames read back zero padded
   srcp_frame u_frame (
      .clock(clock),
      .reset_n(reset_n),
      .clear(!recording_r || state_r == ST_SYNC),
      .release_frame(release_frame),
      .enc_valid(enc_valid),
      .enc_word(enc_word),
      .enc_end(enc_end),
      .rd_idx(rd_idx_r),
      .rd_word(frame_word),
      .full_r(frame_full)
   );

   // a command is taken only while no answer is pending or syncing
   assign cmd_ok = !resp_valid_r && state_r != ST_SYNC;
   assign flags = {4'h0, rate_r, 2'b00, poll_sync_r, vad_en_r,
                   recording_r, frame_full, resp_valid_r, cmd_ok};
   // last frame end of the synchronisation wait
   assign sync_done = state_r == ST_SYNC && enc_end &&
                      sync_cnt_r == `SRCP_SYNC_FRAMES - 2'b01;

   // ****************************************
   // command interpreter
   // ****************************************
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= ST_IDLE;
         data_phase_r <= 1'b0;
         rate_r <= `SRCP_RATE_RST;
         sess_words_r <= `SRCP_FS_85;
         left_r <= 5'h00;
         rd_idx_r <= 4'h0;
         sync_cnt_r <= 2'b00;
         status_r <= 16'h0000;
         poll_sync_r <= 1'b0;
         vad_en_r <= 1'b0;
         recording_r <= 1'b0;
         transfer_window_n_r <= 1'b1;
         transfer_path_sel_r <= 2'b00;
         peak_r <= 1'b0;
         release_frame <= 1'b0;
      end else begin
         release_frame <= 1'b0;
         if (enc_end && recording_r)
            peak_r <= enc_peak; // level flag of the newest frame
         // synchronise for one to two frame periods
         if (state_r == ST_SYNC && enc_end) begin
            if (sync_done) begin
               state_r <= state_nxt;
               sync_cnt_r <= 2'b00;
            end else begin
               sync_cnt_r <= sync_cnt_r + 2'b01;
            end
         end
         // decode one accepted command word
         if (reg_wr && reg_addr == `SRCP_OFS_CMD && cmd_ok) begin
            status_r <= reg_wdata;
            if (reg_wdata == `SRCP_CMD_IDLE || reg_wdata == `SRCP_CMD_STOP)
            begin
               // ends record and drops any waiting frame
               recording_r <= 1'b0;
               state_r <= ST_IDLE;
               data_phase_r <= 1'b0;
               transfer_window_n_r <= 1'b1;
            end else if (reg_wdata[15:4] == `SRCP_CMD_RATE_HI &&
                         reg_wdata[3:0] != 4'he) begin
               if (srcp_words(reg_wdata[3:0]) == 5'h00)
                  status_r <= `SRCP_STS_ZERO;
               else if (recording_r && !(srcp_g723(rate_r) &&
                        srcp_g723(reg_wdata[3:0]) &&
                        sess_words_r == `SRCP_FS_63))
                  status_r <= `SRCP_STS_ZERO;
               else
                  rate_r <= reg_wdata[3:0];
            end else if (reg_wdata == `SRCP_CMD_VAD) begin
               vad_en_r <= 1'b1;
            end else if (reg_wdata == `SRCP_CMD_POLL) begin
               poll_sync_r <= 1'b1;
            end else if (state_r == ST_IDLE &&
                         reg_wdata[15:2] == `SRCP_CMD_REC1_HI) begin
               // session word count fixed by the rate at start
               recording_r <= 1'b1;
               state_r <= ST_SYNC;
               sess_words_r <= srcp_words(rate_r);
               transfer_path_sel_r <= reg_wdata[1:0];
               sync_cnt_r <= 2'b00;
            end else if (recording_r &&
                         reg_wdata[15:8] == `SRCP_CMD_XFER_HI) begin
               if (data_phase_r) begin
                  // one speech word per transfer command
                  status_r <= frame_word;
                  rd_idx_r <= rd_idx_r + 4'h1;
                  left_r <= left_r - 5'h01;
                  if (left_r == 5'h01) begin
                     data_phase_r <= 1'b0;
                     transfer_window_n_r <= 1'b1;
                     release_frame <= 1'b1;
                     state_r <= ST_C2;
                  end
               end else if (state_r == ST_C2) begin
                  status_r <= {`SRCP_CMD_XFER_HI, 8'h00} |
                     (peak_r ? `SRCP_STS_PEAK : 16'h0000);
                  state_r <= ST_C3;
               end else begin
                  // grant a whole frame or nothing
                  if (frame_full && reg_wdata[7:0] != 8'h00) begin
                     status_r <= {`SRCP_CMD_XFER_HI, 3'b000,
                                  sess_words_r};
                     left_r <= sess_words_r;
                     rd_idx_r <= 4'h0;
                     data_phase_r <= 1'b1;
                     transfer_window_n_r <= 1'b0;
                  end else begin
                     status_r <= {`SRCP_CMD_XFER_HI, 8'h00};
                     state_r <= ST_C2;
                  end
               end
            end else begin
               status_r <= `SRCP_STS_ZERO; // unknown command
            end
         end
      end
   end

   // ****************************************
   // sync step of the record phases
   // ****************************************
   // leaves sync once the configured count of frame ends has passed
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: state_nxt = ST_IDLE;
         ST_SYNC: begin
            if (sync_done)
               state_nxt = ST_C2;
         end
         ST_C2: state_nxt = ST_C2;
         ST_C3: state_nxt = ST_C3;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // answer flag: set on command other than record start or on sync end, cleared by status read
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         resp_valid_r <= 1'b0;
      end else if ((reg_wr && reg_addr == `SRCP_OFS_CMD && cmd_ok &&
                    !(state_r == ST_IDLE &&
                      reg_wdata[15:2] == `SRCP_CMD_REC1_HI &&
                      reg_wdata[15:4] != `SRCP_CMD_RATE_HI)) ||
                   (state_r == ST_SYNC && enc_end &&
                    sync_cnt_r == `SRCP_SYNC_FRAMES - 2'b01)) begin
         resp_valid_r <= 1'b1; // set wins over the read clear
      end else if (reg_rd && reg_addr == `SRCP_OFS_STATUS) begin
         resp_valid_r <= 1'b0;
      end
   end

   // ****************************************
   // playback frame type
   // ****************************************
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         play_type_r <= 2'b00;
         play_typed_r <= 1'b0;
      end else if (play_first_valid) begin
         play_typed_r <= srcp_g723(rate_r);
         // type bits carry meaning only at 6.3 and 5.3
         if (srcp_g723(rate_r))
            play_type_r <= play_first_bits;
         else
            play_type_r <= 2'b00;
      end
   end

   // ****************************************
   // register read port
   // ****************************************
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_r <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SRCP_OFS_STATUS: reg_rdata_r <= status_r;
            `SRCP_OFS_FLAGS: reg_rdata_r <= flags;
            default: reg_rdata_r <= 16'h0000;
         endcase
      end else begin
         // idle cycles drive zero read data
         reg_rdata_r <= 16'h0000;
      end
   end
endmodule // srcp_core
`default_nettype wire

// >>> core/srcp_frame.v
// single compressed frame store with zero padding on read-out
`timescale 1ns/100ps
`default_nettype none
`include "srcp_map.vh"
module srcp_frame (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // control
   input wire clear,
   input wire release_frame,
   // encoder side
   input wire enc_valid,
   input wire [15:0] enc_word,
   input wire enc_end,
   // read side
   input wire [3:0] rd_idx,
   output wire [15:0] rd_word,
   output reg full_r
);
   reg [15:0] mem [0:`SRCP_BUF_WORDS-1];
   reg [4:0] count_r;

   // words are taken only while no finished frame waits
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count_r <= 5'h00;
         full_r <= 1'b0;
      end else if (clear || release_frame) begin
         count_r <= 5'h00;
         full_r <= 1'b0;
      end else if (!full_r) begin
         if (enc_valid && count_r < `SRCP_BUF_WORDS)
            count_r <= count_r + 5'h01;
         if (enc_end)
            full_r <= 1'b1;
      end
   end

   // storage array has no reset
   always @(posedge clock) begin
      if (!full_r && enc_valid && count_r < `SRCP_BUF_WORDS)
         mem[count_r[3:0]] <= enc_word;
   end

   // words past the encoded ones read as zero padding
   assign rd_word = ({1'b0, rd_idx} < count_r) ? mem[rd_idx] : 16'h0000;
endmodule // srcp_frame
`default_nettype wire

// >>> core/srcp_map.vh
// offsets, field codes, reset values and counts of the record command block
`ifndef SRCP_MAP_VH
`define SRCP_MAP_VH
// register offsets on the plain register port
`define SRCP_OFS_CMD 4'h0
`define SRCP_OFS_STATUS 4'h4
`define SRCP_OFS_FLAGS 4'h8
// flag register bit positions
`define SRCP_FLG_ACCEPT 0
`define SRCP_FLG_RESP 1
`define SRCP_FLG_RXRDY 2
`define SRCP_FLG_REC 3
`define SRCP_FLG_VAD 4
`define SRCP_FLG_POLL 5
`define SRCP_FLG_RATE_LO 8
// command and status words
`define SRCP_CMD_IDLE 16'h0000
`define SRCP_CMD_STOP 16'h5120
`define SRCP_CMD_POLL 16'h5102
`define SRCP_CMD_VAD 16'h513e
`define SRCP_CMD_RATE_HI 12'h513
`define SRCP_CMD_REC1_HI 14'h0700
`define SRCP_CMD_XFER_HI 8'h10
`define SRCP_STS_ZERO 16'h0000
`define SRCP_STS_PEAK 16'h0010
// rate codes and their reset value
`define SRCP_RATE_85 4'h0
`define SRCP_RATE_63 4'h1
`define SRCP_RATE_53 4'h2
`define SRCP_RATE_48 4'h3
`define SRCP_RATE_41 4'h4
`define SRCP_RATE_RST 4'h0
// frame sizes in 16-bit words
`define SRCP_FS_85 5'h10
`define SRCP_FS_63 5'h0c
`define SRCP_FS_53 5'h0a
`define SRCP_FS_48 5'h09
`define SRCP_FS_41 5'h08
`define SRCP_BUF_WORDS 16
// frame ends to wait before the first record answer
`define SRCP_SYNC_FRAMES 2'h2
`endif

// >>> sim/srcp_core_checker.sv
// timing properties of the record command block seen at its ports
`timescale 1ns/100ps
`default_nettype none
module srcp_core_checker (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register port and sources
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata_r,
   input wire logic enc_valid,
   input wire logic [15:0] enc_word,
   input wire logic enc_end,
   input wire logic enc_peak,
   input wire logic play_first_valid,
   input wire logic [1:0] play_first_bits,
   // outputs of the block
   input wire logic transfer_window_n_r,
   input wire logic [1:0] transfer_path_sel_r,
   input wire logic [1:0] play_type_r,
   input wire logic play_typed_r,
   input wire logic vad_en_r,
   input wire logic recording_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // a write to the command offset
   wire logic wr_cmd = reg_wr && reg_addr == 4'h0;
   a_rdata_after_read: assert property (
      reg_rdata_r != 16'h0000 |-> $past(reg_rd))
      else $error("read data outside read cycle");
   a_vad_by_command: assert property (
      $rose(vad_en_r) |-> $past(wr_cmd && reg_wdata == 16'h513e))
      else $error("vad enabled without its command");
   a_record_end_cmd: assert property (
      $fell(recording_r) |-> $past(wr_cmd &&
         (reg_wdata == 16'h0000 || reg_wdata == 16'h5120)))
      else $error("record ended without idle or stop");
   a_window_opens: assert property (
      $fell(transfer_window_n_r) |-> $past(wr_cmd &&
         reg_wdata[15:8] == 8'h10 && reg_wdata[7:0] != 8'h00))
      else $error("window opened without a count request");
   a_window_closes: assert property (
      $rose(transfer_window_n_r) |-> $past(wr_cmd))
      else $error("window closed without a command");
   a_window_in_rec: assert property (
      !transfer_window_n_r |-> recording_r)
      else $error("window open outside record");
   a_play_examined: assert property (
      ($changed(play_typed_r) || $changed(play_type_r)) |->
         $past(play_first_valid))
      else $error("play type changed without a frame");
   a_type_untyped: assert property (
      play_type_r != 2'b00 |-> play_typed_r)
      else $error("frame type given while not examined");
   a_path_from_c1: assert property (
      $changed(transfer_path_sel_r) |->
         $past(wr_cmd && reg_wdata[15:2] == 14'h0700))
      else $error("path field changed without record start");
endmodule // srcp_core_checker
bind srcp_core srcp_core_checker u_chk (.clock(clock), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_r(reg_rdata_r), .enc_valid(enc_valid), .enc_word(enc_word),
   .enc_end(enc_end), .enc_peak(enc_peak), .play_first_valid(play_first_valid),
   .play_first_bits(play_first_bits), .transfer_window_n_r(transfer_window_n_r),
   .transfer_path_sel_r(transfer_path_sel_r), .play_type_r(play_type_r),
   .play_typed_r(play_typed_r), .vad_en_r(vad_en_r), .recording_r(recording_r));
`default_nettype wire

// >>> sim/srcp_enc_model.sv
// encoder frame source standing in for the speech encoder
`timescale 1ns/100ps
`default_nettype none
module srcp_enc_model (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // frame request
   input wire logic go,
   input wire logic [4:0] n_words,
   input wire logic peak_in,
   // frame output
   output logic enc_valid,
   output logic [15:0] enc_word,
   output logic enc_end,
   output logic enc_peak,
   output logic busy
);
   logic [4:0] cnt;
   // emits n_words words, then one frame end carrying the peak level
   always @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         {enc_valid, enc_end, enc_peak, busy, cnt} <= '0;
         enc_word <= 16'h0000;
      end else begin
         enc_valid <= 1'b0;
         enc_end <= 1'b0;
         enc_peak <= 1'b0;
         enc_word <= ~enc_word; // idle word never repeats the last one
         if (go && !busy) begin
            busy <= 1'b1;
            cnt <= 5'h00;
         end else if (busy && cnt < n_words) begin
            enc_valid <= 1'b1;
            enc_word <= 16'h5a00 + {11'h000, cnt};
            cnt <= cnt + 5'h01;
         end else if (busy) begin
            enc_end <= 1'b1;
            enc_peak <= peak_in;
            busy <= 1'b0;
         end
      end
   end
endmodule // srcp_enc_model
`default_nettype wire

// >>> sim/tb_srcp_core.sv
// self-checking bench for the record command block
`timescale 1ns/100ps
`default_nettype none
module tb_srcp_core;
   logic clock, reset_n, reg_wr, reg_rd, go, pk, pfv, t;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, s, f, e;
   logic [4:0] nw;
   logic [1:0] pbits;
   logic [31:0] seed = 32'h6f7f_476b;
   wire enc_valid, enc_end, enc_peak, busy, win_n, ptyped, vad, rec;
   wire [15:0] enc_word, rdata;
   wire [1:0] path, ptype;
   int failures, n_compared, i, k, r;
   srcp_core dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(rdata), .enc_valid(enc_valid), .enc_word(enc_word),
      .enc_end(enc_end), .enc_peak(enc_peak), .play_first_valid(pfv),
      .play_first_bits(pbits), .transfer_window_n_r(win_n),
      .transfer_path_sel_r(path), .play_type_r(ptype), .play_typed_r(ptyped),
      .vad_en_r(vad), .recording_r(rec));
   srcp_enc_model u_enc (.clock(clock), .reset_n(reset_n), .go(go),
      .n_words(nw), .peak_in(pk), .enc_valid(enc_valid), .enc_word(enc_word),
      .enc_end(enc_end), .enc_peak(enc_peak), .busy(busy));
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected drained word: source pattern, zero padded past the frame
   function logic [15:0] exp_word(int idx, int n);
      return idx < n ? 16'h5a00 + idx[15:0] : 16'h0000;
   endfunction
   task check(logic [15:0] seen, logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("compared %0d, failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task wr(logic [3:0] a, logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task rd(logic [3:0] a, output logic [15:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded poll of one flag bit
   task poll(int b);
      for (k = 0; k < 3000; k++) begin
         rd(4'h8, f);
         if (f[b] === 1'b1) break;
      end
      if (k == 3000) begin
         failures++;
         final_report;
      end
   endtask
   task cmd(logic [15:0] c, logic [15:0] exp);
      poll(0);
      wr(4'h0, c);
      poll(1);
      rd(4'h4, s);
      check(s, exp);
   endtask
   task frame(logic [4:0] n, logic p);
      @(posedge clock);
      go <= 1'b1;
      nw <= n;
      pk <= p;
      @(posedge clock);
      go <= 1'b0;
      // busy rises at the edge that takes go, so look from the next one
      for (k = 0; k < 40; k++) begin
         @(posedge clock);
         if (busy === 1'b0) break;
      end
      if (k == 40) begin
         failures++;
         final_report;
      end
      repeat (2) @(posedge clock);
   endtask
   // record start: two frame ends synchronise before the echo
   task rec_start;
      poll(0);
      wr(4'h0, 16'h1c00);
      frame(5'd16, 1'b0);
      frame(5'd16, 1'b0);
      poll(1);
      rd(4'h4, s);
      check(s, 16'h1c00);
      check({13'h0000, rec, path}, 16'h0004);
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      {reset_n, reg_wr, reg_rd, go, pk, pfv, t} = '0;
      {reg_addr, reg_wdata, nw, pbits} = '0;
      repeat (16) @(posedge clock);
      reset_n <= 1'b1;
      rd(4'h8, f);
      check(f, 16'h0001);
      rd(4'hc, f);
      check(f, 16'h0000);
      // code e is the vad enable word, the other reserved codes answer zero
      for (i = 0; i < 16; i++) begin
         e = i < 5 ? 16'h5130 + i[15:0] : 16'h0000;
         if (i == 14) e = 16'h513e;
         cmd(16'h5130 + i[15:0], e);
      end
      rd(4'h8, f);
      check({12'h000, f[11:8]}, 16'h0004);
      check({15'h0000, vad}, 16'h0001);
      cmd(16'h513e, 16'h513e);
      check({15'h0000, vad}, 16'h0001);
      $display("test rates and vad done");
      // first two passes pin the two typed rates, the rest are random
      for (i = 0; i < 8; i++) begin
         r = i < 2 ? i + 1 : int'(xs() % 5);
         cmd(16'h5130 + r[15:0], 16'h5130 + r[15:0]);
         t = (r == 1 || r == 2);
         @(posedge clock);
         pfv <= 1'b1;
         pbits <= 2'(xs());
         @(posedge clock);
         pfv <= 1'b0;
         #1 e = {13'h0000, t, t ? pbits : 2'b00};
         check({13'h0000, ptyped, ptype}, e);
      end
      $display("test playback type done");
      cmd(16'h5130, 16'h5130);
      cmd(16'h5102, 16'h5102);
      rec_start;
      cmd(16'h1000, 16'h1000);
      cmd(16'h1010, 16'h1000);
      check({15'h0000, win_n}, 16'h0001);
      frame(5'd16, 1'b1);
      cmd(16'h1000, 16'h1010);
      cmd({8'h10, 8'(xs()) | 8'h01}, 16'h1010);
      check({15'h0000, win_n}, 16'h0000);
      for (i = 0; i < 16; i++)
         cmd(16'h1000, exp_word(i, 16));
      check({15'h0000, win_n}, 16'h0001);
      cmd(16'h0000, 16'h0000);
      check({15'h0000, rec}, 16'h0000);
      $display("test record 8.5 done");
      // restart at 6.3, then switch to 5.3 inside the session and try 8.5
      cmd(16'h5131, 16'h5131);
      rec_start;
      frame(5'd2, 1'b0);
      cmd(16'h1000, 16'h1000);
      cmd(16'h1005, 16'h100c);
      for (i = 0; i < 12; i++)
         cmd(16'h1000, exp_word(i, 2));
      cmd(16'h5132, 16'h5132);
      cmd(16'h5130, 16'h0000);
      rd(4'h8, f);
      check({12'h000, f[11:8]}, 16'h0002);
      frame(5'd10, 1'b1);
      cmd(16'h1000, 16'h1010);
      cmd(16'h1010, 16'h100c);
      for (i = 0; i < 12; i++)
         cmd(16'h1000, exp_word(i, 10));
      cmd(16'h5120, 16'h5120);
      check({14'h0000, rec, win_n}, 16'h0001);
      $display("test record 6.3 switch done");
      final_report;
   end
endmodule // tb_srcp_core
`default_nettype wire
